/* File: bench/asg_gpio_asserts.sv */
`timescale 1ns/1ps
module asg_gpio_asserts (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        clk_en,
   // Register side
   input wire logic [3:0]  bank_sel,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   // Pins
   input wire logic [7:0]  first_pin_out,
   input wire logic [7:0]  first_pin_oe,
   input wire logic [7:0]  second_pin_in,
   input wire logic [7:0]  second_pin_out,
   input wire logic [7:0]  second_pin_oe,
   input wire logic [7:0]  third_pin_oe,
   // Converter and peripherals
   input wire logic [15:0] analog_chan_en,
   input wire logic        ext_vref_en,
   input wire logic        third_pulse_en,
   input wire logic        third_pulse_level,
   input wire logic        third_capture_input
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_first_analog_quiet: assert property ((first_pin_oe & analog_chan_en[11:4]) == 8'h00)
      else $error("first port drives an analog pin");
   a_second_low_map: assert property ((second_pin_oe[3:0] & {analog_chan_en[0],
      analog_chan_en[1], analog_chan_en[2], analog_chan_en[3]}) == 4'h0)
      else $error("second port drives an analog pin");
   a_third_high_map: assert property ((third_pin_oe[7:4] & analog_chan_en[15:12]) == 4'h0)
      else $error("third port drives an analog pin");
   a_vref_needs_analog: assert property (ext_vref_en |-> analog_chan_en[1:0] == 2'h3)
      else $error("reference pins not analog");
   a_capture_copy: assert property (clk_en |=> third_capture_input == $past(second_pin_in[4]))
      else $error("capture input does not follow its pin");
   a_pulse_drive: assert property (clk_en && third_pulse_en |=> second_pin_oe[5] &&
      second_pin_out[5] == $past(third_pulse_level)) else $error("pulse output not driven");
   a_latch_to_pin: assert property (reg_wr && clk_en && bank_sel == asg_pkg::BANK_FG &&
      reg_addr == asg_pkg::OFS_FIRST_DATA ##1 clk_en |=> first_pin_out == $past(reg_wdata, 2))
      else $error("first port latch not on pins");
   a_reset_analog: assert property ($fell(rst) |-> analog_chan_en == 16'hFFFF &&
      first_pin_oe == 8'h00) else $error("reset left pins digital or driven");
   c_bank_h_write: cover property (reg_wr && bank_sel == asg_pkg::BANK_H);
   c_vref_on: cover property ($rose(ext_vref_en));
   c_pulse_out: cover property (third_pulse_en ##1 second_pin_oe[5]);
endmodule // asg_gpio_asserts
bind asg_gpio asg_gpio_asserts u_asserts (.*);

/* File: bench/tb_asg_gpio.sv */
`timescale 1ns/1ps
module tb_asg_gpio;
   logic        ref_clk, rst, clk_en, reg_wr, reg_rd, ext_vref_en, result_justify;
   logic        third_pulse_en, third_pulse_level, serial_tx_en, serial_tx_level;
   logic        serial_dt_drive, serial_dt_level, third_capture_input, serial_rx_input;
   logic [1:0]  conversion_clock_select;
   logic [3:0]  bank_sel;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, first_pin_in, first_pin_out, first_pin_oe;
   logic [7:0]  second_pin_in, second_pin_out, second_pin_oe;
   logic [7:0]  third_pin_in, third_pin_out, third_pin_oe;
   logic [15:0] analog_chan_en, ana;
   int          n_errors = 0;
   int          n_tests = 0;
   asg_gpio u_dut (.*);
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [3:0] b, logic [7:0] a, logic [7:0] d);
      @(posedge ref_clk);
      {bank_sel, reg_addr, reg_wdata, reg_wr} <= {b, a, d, 1'b1};
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [3:0] b, logic [7:0] a, logic [7:0] e);
      @(posedge ref_clk);
      {bank_sel, reg_addr, reg_rd} <= {b, a, 1'b1};
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
   endtask
   // Outputs follow register state one cycle after the write lands
   task automatic settle;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      {rst, clk_en, reg_wr, reg_rd, bank_sel, reg_addr, reg_wdata} = {3'b110, 1'b0, 20'h0};
      {first_pin_in, second_pin_in, third_pin_in} = 24'hA5_00_C3;
      {third_pulse_en, third_pulse_level, serial_tx_en, serial_tx_level} = 4'h0;
      {serial_dt_drive, serial_dt_level} = 2'b00;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      rd(asg_pkg::BANK_FG, asg_pkg::OFS_FIRST_DIR, 8'hFF);
      rd(asg_pkg::BANK_FG, asg_pkg::OFS_SECOND_DIR, 8'hFF);
      rd(asg_pkg::BANK_H, asg_pkg::OFS_THIRD_DIR, 8'hFF);
      rd(asg_pkg::BANK_FG, asg_pkg::OFS_FIRST_DATA, 8'h00);
      chk("analog_chan_en", 16'hFFFF, analog_chan_en);
      chk("pin_oe", 16'h0000, {first_pin_oe, third_pin_oe});
      wr(asg_pkg::BANK_FG, asg_pkg::OFS_FIRST_DIR, 8'h00);
      wr(asg_pkg::BANK_FG, asg_pkg::OFS_SECOND_DIR, 8'h00);
      wr(asg_pkg::BANK_H, asg_pkg::OFS_THIRD_DIR, 8'h00);
      wr(asg_pkg::BANK_FG, asg_pkg::OFS_FIRST_DATA, 8'h55);
      wr(asg_pkg::BANK_H, asg_pkg::OFS_THIRD_DATA, 8'h96);
      // Step the pin selection through every analog split
      for (int s = 0; s <= 8; s++) begin
         ana = (s >= 8) ? 16'h0000 : 16'((32'h1 << (16 - 2 * s)) - 1);
         wr(asg_pkg::BANK_FG, asg_pkg::OFS_CONV_CFG, 8'(s));
         settle();
         chk("analog_chan_en", ana, analog_chan_en);
         chk("first_pin_oe", {8'h00, ~ana[11:4]}, {8'h00, first_pin_oe});
         chk("second_oe_low", {12'h0, ~{ana[0], ana[1], ana[2], ana[3]}},
             {12'h0, second_pin_oe[3:0]});
         chk("third_pin_oe", {8'h00, ~ana[15:12], 4'hF}, {8'h00, third_pin_oe});
         chk("ext_vref_en", {15'h0, s[0] && s < 8}, {15'h0, ext_vref_en});
      end
      chk("pin_out", 16'h5596, {first_pin_out, third_pin_out});
      wr(asg_pkg::BANK_FG, asg_pkg::OFS_CONV_CFG, 8'hDE);
      rd(asg_pkg::BANK_FG, asg_pkg::OFS_CONV_CFG, 8'hCE);
      chk("cfg_fields", 16'h0006, {13'h0, conversion_clock_select, result_justify});
      wr(asg_pkg::BANK_FG, asg_pkg::OFS_FIRST_DIR, 8'h03);
      settle();
      chk("first_pin_oe", 16'h00FC, {8'h00, first_pin_oe});
      rd(asg_pkg::BANK_FG, asg_pkg::OFS_FIRST_DATA, 8'hA5);
      rd(asg_pkg::BANK_H, asg_pkg::OFS_THIRD_DATA, 8'hC3);
      chk("first_pin_out", 16'h0055, {8'h00, first_pin_out});
      rd(4'h5, 8'h14, 8'h00);
      // A write while the enable is low must not land
      clk_en <= 1'b0;
      wr(asg_pkg::BANK_FG, asg_pkg::OFS_FIRST_DATA, 8'hAA);
      settle();
      chk("frozen_pin_out", 16'h0055, {8'h00, first_pin_out});
      clk_en <= 1'b1;
      // Peripherals override an input direction on the upper second port pins
      wr(asg_pkg::BANK_FG, asg_pkg::OFS_SECOND_DIR, 8'hFF);
      {third_pulse_en, serial_tx_en, serial_tx_level, serial_dt_drive} <= 4'hF;
      {serial_dt_level, second_pin_in} <= {1'b1, 8'h50};
      settle();
      chk("second_top", 16'h0037, {10'h0, second_pin_out[7:5], second_pin_oe[7:5]});
      chk("capture_rx", 16'h0003, {14'h0, third_capture_input, serial_rx_input});
      rd(asg_pkg::BANK_FG, asg_pkg::OFS_SECOND_DATA, 8'h50);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      settle();
      chk("analog_chan_en", 16'hFFFF, analog_chan_en);
      rd(asg_pkg::BANK_H, asg_pkg::OFS_THIRD_DIR, 8'hFF);
      end_of_test();
   end
   initial begin
      #(40 * 3000);
      n_errors++;
      end_of_test();
   end
endmodule // tb_asg_gpio

/* File: rtl/asg_gpio.sv */
`timescale 1ns/1ps
// Summary of operation
// - Direction bit one makes the pin an input, driver off, except second port bits 5..7 while a peripheral drives them.
// - Direction bit zero drives the pin from its output latch bit unless the pin is analog or a peripheral drives it.
// - Data reads return pin levels, zero on analog pins; writes only update the output latch.
// - First port bits 0..7 share converter channels 4..11 in order.
// - Second port bits 0..3 share channels 3..0 in reverse order.
// - Second port bits 2 and 3 carry external negative and positive references.
// - Second port bits 4..7: capture in, pulse out, serial data, serial clock.
// - Reset leaves second port low nibble analog until configuration changes.
// - Third port bits 4..7 share channels 12..15 in order.
// - Third port low nibble is plain digital input or output only.
// - Reset leaves third port high nibble analog until configuration changes.
// - Reset leaves every first port pin analog until reconfigured.
module asg_gpio (
   // Clock, reset, enable
   input  wire  logic        ref_clk,
   input  wire  logic        rst,
   input  wire  logic        clk_en,
   // Banked register access
   input  wire  logic [3:0]  bank_sel,
   input  wire  logic [7:0]  reg_addr,
   input  wire  logic        reg_wr,
   input  wire  logic [7:0]  reg_wdata,
   input  wire  logic        reg_rd,
   output logic [7:0]        reg_rdata,
   // First port pins
   input  wire  logic [7:0]  first_pin_in,
   output logic [7:0]        first_pin_out,
   output logic [7:0]        first_pin_oe,
   // Second port pins
   input  wire  logic [7:0]  second_pin_in,
   output logic [7:0]        second_pin_out,
   output logic [7:0]        second_pin_oe,
   // Third port pins
   input  wire  logic [7:0]  third_pin_in,
   output logic [7:0]        third_pin_out,
   output logic [7:0]        third_pin_oe,
   // Converter side
   output logic [15:0]       analog_chan_en,
   output logic              ext_vref_en,
   output logic [1:0]        conversion_clock_select,
   output logic              result_justify,
   // Peripheral side
   input  wire  logic        third_pulse_en,
   input  wire  logic        third_pulse_level,
   input  wire  logic        serial_tx_en,
   input  wire  logic        serial_tx_level,
   input  wire  logic        serial_dt_drive,
   input  wire  logic        serial_dt_level,
   output logic              third_capture_input,
   output logic              serial_rx_input
);

   typedef struct packed {
      logic [7:0]  dir_f;
      logic [7:0]  dir_g;
      logic [7:0]  dir_h;
      logic [7:0]  lat_f;
      logic [7:0]  lat_g;
      logic [7:0]  lat_h;
      logic [7:0]  cfg;
      logic [7:0]  rdata;
      logic [7:0]  out_f;
      logic [7:0]  out_g;
      logic [7:0]  out_h;
      logic [7:0]  oe_f;
      logic [7:0]  oe_g;
      logic [7:0]  oe_h;
      logic [15:0] ana;
      logic        vref;
      logic        cap;
      logic        rx;
   } asg_state_t;

   asg_state_t st_r;
   asg_state_t st_nxt;

   // Register hit decode
   function automatic logic hit(input logic [3:0] b, input logic [7:0] a,
                                input logic [3:0] wb, input logic [7:0] wa);
      hit = (b == wb) && (a == wa);
   endfunction

   // Channels left analog: fewer as the select grows, none from eight up
   function automatic logic [15:0] chan_mask(input logic [3:0] sel);
      logic [15:0] m;
      m = '0;
      for (int c = 0; c < asg_pkg::NUM_CHAN; c++) begin
         m[c] = (sel[3] == 1'b0) && (c < (asg_pkg::NUM_CHAN - 2 * int'(sel)));
      end
      chan_mask = m;
   endfunction

   logic [15:0] ch_ana;
   logic [7:0]  ana_f;
   logic [7:0]  ana_g;
   logic [7:0]  ana_h;
   logic [7:0]  drv_f;
   logic [7:0]  drv_g;
   logic [7:0]  drv_h;
   logic [3:0]  sel;
   // Register hits
   logic        hit_f_dir;
   logic        hit_f_data;
   logic        hit_g_dir;
   logic        hit_g_data;
   logic        hit_cfg;
   logic        hit_h_dir;
   logic        hit_h_data;

   assign sel    = st_r.cfg[asg_pkg::CFG_SEL_LSB +: asg_pkg::CFG_SEL_W];
   assign ch_ana = chan_mask(sel);

   // Bank five registers
   assign hit_f_dir  = hit(bank_sel, reg_addr, asg_pkg::BANK_FG, asg_pkg::OFS_FIRST_DIR);
   assign hit_f_data = hit(bank_sel, reg_addr, asg_pkg::BANK_FG, asg_pkg::OFS_FIRST_DATA);
   assign hit_g_dir  = hit(bank_sel, reg_addr, asg_pkg::BANK_FG, asg_pkg::OFS_SECOND_DIR);
   assign hit_g_data = hit(bank_sel, reg_addr, asg_pkg::BANK_FG, asg_pkg::OFS_SECOND_DATA);
   assign hit_cfg    = hit(bank_sel, reg_addr, asg_pkg::BANK_FG, asg_pkg::OFS_CONV_CFG);
   // Bank eight registers
   assign hit_h_dir  = hit(bank_sel, reg_addr, asg_pkg::BANK_H, asg_pkg::OFS_THIRD_DIR);
   assign hit_h_data = hit(bank_sel, reg_addr, asg_pkg::BANK_H, asg_pkg::OFS_THIRD_DATA);

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_map
         assign ana_f[gi] = ch_ana[asg_pkg::FIRST_CHAN_BASE + gi];

         assign drv_f[gi] = ~st_r.dir_f[gi] & ~ana_f[gi];
         assign drv_g[gi] = ~st_r.dir_g[gi] & ~ana_g[gi];
         assign drv_h[gi] = ~st_r.dir_h[gi] & ~ana_h[gi];

         if (gi < 4) begin : g_low
            assign ana_g[gi] = ch_ana[asg_pkg::SECOND_CHAN_TOP - gi];
            assign ana_h[gi] = 1'b0;
         end else begin : g_high
            assign ana_g[gi] = 1'b0;
            assign ana_h[gi] = ch_ana[asg_pkg::THIRD_CHAN_BASE + gi - 4];
         end
      end
   endgenerate

   always_comb begin
      st_nxt = st_r;

      if (reg_wr) begin
         if (hit_f_dir) begin
            st_nxt.dir_f = reg_wdata;
         end

         if (hit_f_data) begin
            st_nxt.lat_f = reg_wdata;
         end

         if (hit_g_dir) begin
            st_nxt.dir_g = reg_wdata;
         end

         if (hit_g_data) begin
            st_nxt.lat_g = reg_wdata;
         end

         if (hit_cfg) begin
            st_nxt.cfg = reg_wdata & asg_pkg::CFG_WR_MASK;
         end

         if (hit_h_dir) begin
            st_nxt.dir_h = reg_wdata;
         end

         if (hit_h_data) begin
            st_nxt.lat_h = reg_wdata;
         end
      end

      // Unmapped reads return zero; read data holds until the next read
      if (reg_rd) begin
         st_nxt.rdata = 8'h00;
         if (hit_f_dir) begin
            st_nxt.rdata = st_r.dir_f;
         end

         if (hit_f_data) begin
            st_nxt.rdata = first_pin_in & ~ana_f;
         end

         if (hit_g_dir) begin
            st_nxt.rdata = st_r.dir_g;
         end

         if (hit_g_data) begin
            st_nxt.rdata = second_pin_in & ~ana_g;
         end

         if (hit_cfg) begin
            st_nxt.rdata = st_r.cfg;
         end

         if (hit_h_dir) begin
            st_nxt.rdata = st_r.dir_h;
         end

         if (hit_h_data) begin
            st_nxt.rdata = third_pin_in & ~ana_h;
         end
      end

      st_nxt.oe_f  = drv_f;
      st_nxt.oe_g  = drv_g;
      st_nxt.oe_h  = drv_h;
      st_nxt.out_f = st_r.lat_f;
      st_nxt.out_g = st_r.lat_g;
      st_nxt.out_h = st_r.lat_h;

      // Peripheral overrides on second port
      // Pulse unit on bit five
      if (third_pulse_en) begin
         st_nxt.oe_g[asg_pkg::G_PWM]  = 1'b1;
         st_nxt.out_g[asg_pkg::G_PWM] = third_pulse_level;
      end

      // Serial data on bit six
      if (serial_dt_drive) begin
         st_nxt.oe_g[asg_pkg::G_SERIAL_RX]  = 1'b1;
         st_nxt.out_g[asg_pkg::G_SERIAL_RX] = serial_dt_level;
      end

      // Serial clock on bit seven
      if (serial_tx_en) begin
         st_nxt.oe_g[asg_pkg::G_SERIAL_TX]  = 1'b1;
         st_nxt.out_g[asg_pkg::G_SERIAL_TX] = serial_tx_level;
      end

      // Peripheral inputs follow the pins whatever the direction
      st_nxt.cap = second_pin_in[asg_pkg::G_CAPTURE];
      st_nxt.rx  = second_pin_in[asg_pkg::G_SERIAL_RX];

      // Converter side
      st_nxt.ana = ch_ana;
      // External references need both pins analog
      st_nxt.vref = sel[0] && ana_g[asg_pkg::G_VREF_NEG] && ana_g[asg_pkg::G_VREF_POS];
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r.dir_f <= asg_pkg::RST_DIR;
         st_r.dir_g <= asg_pkg::RST_DIR;
         st_r.dir_h <= asg_pkg::RST_DIR;

         // Latches and configuration
         st_r.lat_f <= asg_pkg::RST_DATA;
         st_r.lat_g <= asg_pkg::RST_DATA;
         st_r.lat_h <= asg_pkg::RST_DATA;
         st_r.cfg   <= asg_pkg::RST_CONV_CFG;
         st_r.rdata <= 8'h00;

         // Outputs start undriven and analog
         st_r.out_f <= asg_pkg::RST_DATA;
         st_r.out_g <= asg_pkg::RST_DATA;
         st_r.out_h <= asg_pkg::RST_DATA;
         st_r.oe_f  <= 8'h00;
         st_r.oe_g  <= 8'h00;
         st_r.oe_h  <= 8'h00;
         st_r.ana   <= 16'hFFFF;
         st_r.vref  <= 1'b0;
         st_r.cap   <= 1'b0;
         st_r.rx    <= 1'b0;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata               = st_r.rdata;
   assign first_pin_out           = st_r.out_f;
   assign first_pin_oe            = st_r.oe_f;
   assign second_pin_out          = st_r.out_g;
   assign second_pin_oe           = st_r.oe_g;
   assign third_pin_out           = st_r.out_h;
   assign third_pin_oe            = st_r.oe_h;
   assign analog_chan_en          = st_r.ana;
   assign ext_vref_en             = st_r.vref;
   assign conversion_clock_select = st_r.cfg[asg_pkg::CFG_CLK_LSB +: 2];
   assign result_justify          = st_r.cfg[asg_pkg::CFG_JUSTIFY_BIT];
   assign third_capture_input     = st_r.cap;
   assign serial_rx_input         = st_r.rx;

endmodule // asg_gpio

/* File: rtl/asg_pkg.sv */
package asg_pkg;
   // Register banks and offsets
   localparam logic [3:0] BANK_FG          = 4'h5;
   localparam logic [3:0] BANK_H           = 4'h8;
   localparam logic [7:0] OFS_FIRST_DIR    = 8'h10;
   localparam logic [7:0] OFS_FIRST_DATA   = 8'h11;
   localparam logic [7:0] OFS_SECOND_DIR   = 8'h12;
   localparam logic [7:0] OFS_SECOND_DATA  = 8'h13;
   localparam logic [7:0] OFS_CONV_CFG     = 8'h15;
   localparam logic [7:0] OFS_THIRD_DIR    = 8'h10;
   localparam logic [7:0] OFS_THIRD_DATA   = 8'h11;
   // Values after reset
   localparam logic [7:0] RST_DIR          = 8'hFF;
   localparam logic [7:0] RST_DATA         = 8'h00;
   localparam logic [7:0] RST_CONV_CFG     = 8'h00;
   // Converter configuration fields
   localparam logic [7:0] CFG_WR_MASK      = 8'hEF;
   localparam int         CFG_CLK_LSB      = 6;
   localparam int         CFG_JUSTIFY_BIT  = 5;
   localparam int         CFG_SEL_LSB      = 0;
   localparam int         CFG_SEL_W        = 4;
   // Channel numbering of shared pins
   localparam int         NUM_CHAN         = 16;
   localparam int         FIRST_CHAN_BASE  = 4;
   localparam int         SECOND_CHAN_TOP  = 3;
   localparam int         THIRD_CHAN_BASE  = 12;
   // Second port alternate pin positions
   localparam int         G_VREF_NEG       = 2;
   localparam int         G_VREF_POS       = 3;
   localparam int         G_CAPTURE        = 4;
   localparam int         G_PWM            = 5;
   localparam int         G_SERIAL_RX      = 6;
   localparam int         G_SERIAL_TX      = 7;
endpackage
